/* rtl/tws_ctrl.sv */
// two-wire serial controller: shift buffer, prescaler, pending interrupt
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_ctrl
	import tws_pkg::*;
#(
	parameter int PW = 16
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// register port
	input  wire logic [31:0] ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	// serial bus
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE,
	input  wire logic        SCL_I,
	output logic             SCL_O,
	output logic             SCL_OE,
	// interrupt
	output logic             IRQ
);
	// ==========================================================
	// registers
	tws_state_t    state_r;
	logic [7:0]    shift_r;
	logic [7:0]    dbuf_r;
	logic [PW-1:0] presc_r;
	logic [PW-1:0] count;
	logic          pend_r;
	logic          imask_r;
	logic          test_r;
	logic          ack_en_r;
	logic          rx_r;
	logic          soft_rst_r;
	logic [1:0]    bus_condition_select_r;
	logic [3:0]    bit_cnt_r;
	logic [1:0]    phase_r;
	logic          ack_seen_r;
	logic          tick;
	logic          byte_done;
	logic [2:0]    sda_s_r;
	logic [2:0]    scl_s_r;
	logic          sda_in;
	logic          scl_in;
	logic          busy;

	wire wr_ctrl  = WR && ADDR == `TWS_OFS_CTRL;
	wire wr_buf   = WR && ADDR == `TWS_OFS_BUF;
	wire wr_presc = WR && ADDR == `TWS_OFS_PRESCALE;
	wire wr_pend  = WR && ADDR == `TWS_OFS_PEND;
	wire wr_imask = WR && ADDR == `TWS_OFS_IMASK;
	wire wr_test  = WR && ADDR == `TWS_OFS_TEST;
	wire crst     = soft_rst_r;
	assign busy = state_r != ST_IDLE;

	// ==========================================================
	// pin input synchronisers
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sda_s_r <= 3'h7;
			scl_s_r <= 3'h7;
		end else begin
			sda_s_r <= {sda_s_r[1:0], SDA_I};
			scl_s_r <= {scl_s_r[1:0], SCL_I};
		end
	end
	// a change counts once stages two and three agree
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sda_in <= 1'b1;
			scl_in <= 1'b1;
		end else begin
			if (sda_s_r[1] == sda_s_r[2]) sda_in <= sda_s_r[2];
			if (scl_s_r[1] == scl_s_r[2]) scl_in <= scl_s_r[2];
		end
	end

	// ==========================================================
	// prescaler
	tws_prescaler #(.W(PW)) u_presc (
		.clk   (CLK),
		.nrst  (NRST),
		.clr   (crst || state_r == ST_IDLE),
		.presc (presc_r),
		.count (count),
		.tick  (tick)
	);

	// ==========================================================
	// control register
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ack_en_r   <= 1'b0;
			rx_r       <= 1'b0;
			soft_rst_r <= 1'b0;
		end else if (wr_ctrl) begin
			ack_en_r   <= WDATA[`TWS_CTRL_ACK];
			rx_r       <= WDATA[`TWS_CTRL_RX];
			soft_rst_r <= WDATA[`TWS_CTRL_RST];
		end
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			presc_r <= PW'(`TWS_PRESCALE_RST);
		end else if (wr_presc) begin
			presc_r <= WDATA[PW-1:0];
		end
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			imask_r <= 1'b0;
			test_r  <= 1'b0;
		end else begin
			if (wr_imask) imask_r <= WDATA[0];
			if (wr_test) test_r <= WDATA[0];
		end
	end

	// ==========================================================
	// transfer sequencer
	assign byte_done = state_r == ST_BIT && tick && phase_r == 2'h3 && bit_cnt_r == `TWS_BITS_PER_BYTE - 4'h1;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_r   <= ST_IDLE;
			bus_condition_select_r    <= `TWS_BUS_CONDITION_SELECT_NONE;
			phase_r   <= 2'h0;
			bit_cnt_r <= 4'h0;
		end else if (crst) begin
			state_r   <= ST_IDLE;
			bus_condition_select_r    <= `TWS_BUS_CONDITION_SELECT_NONE;
			phase_r   <= 2'h0;
			bit_cnt_r <= 4'h0;
		end else begin
			if (wr_ctrl) bus_condition_select_r <= WDATA[`TWS_CTRL_BUS_CONDITION_SELECT_LO +: 2];
			case (state_r)
				ST_IDLE: begin
					phase_r <= 2'h0;
					// a start written while busy is dropped, not kept for later
					if (wr_ctrl && WDATA[`TWS_CTRL_BUS_CONDITION_SELECT_LO +: 2] == `TWS_BUS_CONDITION_SELECT_START) begin
						state_r <= ST_START;
					end
				end
				ST_START, ST_STOP, ST_RSTRT: begin
					if (tick) begin
						phase_r <= phase_r + 2'h1;
						if (phase_r == 2'h3) begin
							bit_cnt_r <= 4'h0;
							state_r   <= (state_r == ST_STOP) ? ST_IDLE : ST_BIT;
						end
					end
				end
				ST_BIT: begin
					// a far device holding the clock low stretches the high phase
					if (tick && (phase_r != 2'h2 || scl_in)) begin
						phase_r <= phase_r + 2'h1;
						if (phase_r == 2'h3) begin
							bit_cnt_r <= bit_cnt_r + 4'h1;
							if (byte_done) state_r <= ST_HOLD;
						end
					end
				end
				ST_HOLD: begin
					phase_r <= 2'h0;
					if (wr_ctrl && WDATA[`TWS_CTRL_BUS_CONDITION_SELECT_LO +: 2] == `TWS_BUS_CONDITION_SELECT_STOP) begin
						state_r <= ST_STOP;
					end else if (wr_ctrl && WDATA[`TWS_CTRL_BUS_CONDITION_SELECT_LO +: 2] == `TWS_BUS_CONDITION_SELECT_RESTART) begin
						state_r <= ST_RSTRT;
					// a cleared pending bit resumes receive only
					end else if (wr_buf || (rx_r && wr_pend && WDATA[0] && pend_r)) begin
						bit_cnt_r <= 4'h0;
						state_r   <= ST_BIT;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// shift register and read buffer
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			shift_r <= 8'h00;
		end else if (wr_buf) begin
			shift_r <= WDATA[7:0];
		end else if (state_r == ST_BIT && tick && bit_cnt_r < 4'h8) begin
			if (phase_r == 2'h2 && scl_in) shift_r <= {shift_r[6:0], sda_in};
		end
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			dbuf_r <= 8'h00;
		end else if (byte_done) begin
			dbuf_r <= shift_r;
		end
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ack_seen_r <= 1'b0;
		end else if (state_r == ST_BIT && tick && phase_r == 2'h2 && bit_cnt_r == 4'h8 && scl_in) begin
			ack_seen_r <= !sda_in;
		end
	end

	// ==========================================================
	// serial pins, open drain
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			SCL_O  <= 1'b0;
			SCL_OE <= 1'b0;
			SDA_O  <= 1'b0;
			SDA_OE <= 1'b0;
		end else begin
			SCL_O <= 1'b0;
			SDA_O <= 1'b0;
			case (state_r)
				ST_START: begin
					SCL_OE <= phase_r == 2'h3;
					SDA_OE <= phase_r >= 2'h2;
				end
				ST_BIT: begin
					SCL_OE <= phase_r == 2'h0 || phase_r == 2'h3;
					if (bit_cnt_r == 4'h8) begin
						SDA_OE <= rx_r && ack_en_r;
					end else begin
						SDA_OE <= !rx_r && !shift_r[7];
					end
				end
				ST_HOLD:  begin
					SCL_OE <= 1'b1;
					SDA_OE <= SDA_OE;
				end
				ST_STOP:  begin
					SCL_OE <= phase_r == 2'h0;
					SDA_OE <= phase_r <= 2'h2;
				end
				ST_RSTRT: begin
					SCL_OE <= phase_r == 2'h3;
					SDA_OE <= phase_r >= 2'h2;
				end
				default: begin
					SCL_OE <= 1'b0;
					SDA_OE <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// interrupt pending
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pend_r <= 1'b0;
		end else if (crst) begin
			pend_r <= 1'b0;
		end else if (byte_done) begin
			pend_r <= 1'b1;
		end else if (wr_pend && WDATA[0] && pend_r) begin
			pend_r <= 1'b0;
		end
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= pend_r && imask_r;
		end
	end

	// ==========================================================
	// read data
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= 32'h0;
		end else if (RD) begin
			case (ADDR)
				`TWS_OFS_CTRL:     RDATA <= {24'h0, soft_rst_r, busy, bus_condition_select_r, ack_en_r, ack_seen_r, 1'b0, rx_r};
				`TWS_OFS_BUF:      RDATA <= {24'h0, dbuf_r};
				`TWS_OFS_PRESCALE: RDATA <= {{(32-PW){1'b0}}, presc_r};
				`TWS_OFS_COUNT:    RDATA <= test_r ? {{(32-PW){1'b0}}, count} : 32'h0;
				`TWS_OFS_PEND:     RDATA <= {31'h0, pend_r};
				`TWS_OFS_IMASK:    RDATA <= {31'h0, imask_r};
				`TWS_OFS_TEST:     RDATA <= {31'h0, test_r};
				default:           RDATA <= 32'h0;
			endcase
		end else begin
			RDATA <= 32'h0;
		end
	end
endmodule : tws_ctrl

/* rtl/tws_regs.svh */
// register offsets, field positions, reset values and timing counts of the two-wire controller
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_OFS_CTRL      32'hf00f0000
`define TWS_OFS_BUF       32'hf00f0004
`define TWS_OFS_PRESCALE  32'hf00f0008
`define TWS_OFS_COUNT     32'hf00f000c
`define TWS_OFS_PEND      32'hf00f0010
`define TWS_OFS_IMASK     32'hf00f0014
`define TWS_OFS_TEST      32'hf00f0018
`define TWS_CTRL_ACK      3
`define TWS_CTRL_BUS_CONDITION_SELECT_LO  4
`define TWS_CTRL_BUSY     6
`define TWS_CTRL_RST      7
`define TWS_CTRL_RX       0
`define TWS_BUS_CONDITION_SELECT_NONE     2'h0
`define TWS_BUS_CONDITION_SELECT_START    2'h1
`define TWS_BUS_CONDITION_SELECT_STOP     2'h2
`define TWS_BUS_CONDITION_SELECT_RESTART  2'h3
`define TWS_PRESCALE_RST  16'h0000
`define TWS_DIV_MUL       16
`define TWS_DIV_ADD       3
`define TWS_BITS_PER_BYTE 4'h9
`endif

/* rtl/tws_pkg.sv */
// types shared by the two-wire controller files
package tws_pkg;
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_START = 6'b000010,
		ST_BIT   = 6'b000100,
		ST_HOLD  = 6'b001000,
		ST_STOP  = 6'b010000,
		ST_RSTRT = 6'b100000
	} tws_state_t;
endpackage : tws_pkg

/* rtl/tws_prescaler.sv */
// programmable prescaler making a one-cycle quarter-bit tick
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_prescaler #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         clr,
	input  wire logic [W-1:0] presc,
	output logic [W-1:0]      count,
	output logic              tick
);
	// period per tick = (16*(presc+1)+3)/4 is not integral, so count one
	// full serial period and emit four ticks at fixed phases within it
	localparam int PW = W + 5;
	logic [PW-1:0] period;
	logic [PW-1:0] pos_r;
	logic [PW-1:0] q;
	assign period = PW'(`TWS_DIV_MUL) * (PW'(presc) + PW'(1)) + PW'(`TWS_DIV_ADD);
	assign q = period >> 2;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pos_r <= '0;
		end else if (clr || pos_r >= period - PW'(1)) begin
			pos_r <= '0;
		end else begin
			pos_r <= pos_r + PW'(1);
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick <= 1'b0;
		end else begin
			tick <= !clr && (pos_r == '0 || pos_r == q || pos_r == (q << 1) || pos_r == q * PW'(3));
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
		end else begin
			count <= pos_r[W-1:0];
		end
	end
endmodule : tws_prescaler

/* testbench/tws_props.sv */
// port checker for the two-wire controller
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_props (
	input wire logic        CLK,
	input wire logic        NRST,
	input wire logic [31:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic        SDA_OE,
	input wire logic        SCL_OE,
	input wire logic        IRQ
);
	// ======
	// mirrors of written values
	logic [15:0] presc_r;
	logic        mask_r;
	logic        test_r;
	wire logic   mapped = ADDR inside {`TWS_OFS_CTRL, `TWS_OFS_BUF, `TWS_OFS_PRESCALE,
		`TWS_OFS_COUNT, `TWS_OFS_PEND, `TWS_OFS_IMASK, `TWS_OFS_TEST};
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			presc_r <= 16'h0000;
			mask_r  <= 1'b0;
			test_r  <= 1'b0;
		end else if (WR) begin
			if (ADDR == `TWS_OFS_PRESCALE) presc_r <= WDATA[15:0];
			if (ADDR == `TWS_OFS_IMASK) mask_r <= WDATA[0];
			if (ADDR == `TWS_OFS_TEST) test_r <= WDATA[0];
		end
	end
	// ======
	// assertions
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// start: data pulled low while clock high, short prescale
	sequence start_seen;
		$rose(SDA_OE) && !SCL_OE && presc_r < 16'h0010;
	endsequence
	a_start_then_clock: assert property (start_seen |-> ##[1:300] SCL_OE)
		else $error("clock not pulled low after start");
	a_read_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data outside answer cycle");
	a_presc_readback: assert property (RD && ADDR == `TWS_OFS_PRESCALE |=> RDATA == {16'h0, presc_r})
		else $error("prescale readback wrong");
	a_count_gated: assert property (RD && ADDR == `TWS_OFS_COUNT && !test_r |=> RDATA == 32'h0)
		else $error("count readable outside test");
	a_unmapped_zero: assert property (RD && !mapped |=> RDATA == 32'h0)
		else $error("unmapped read not zero");
	a_mask_blocks_irq: assert property (!$past(mask_r) |-> !IRQ)
		else $error("interrupt while masked");
	a_clear_drops_irq: assert property (WR && ADDR == `TWS_OFS_PEND && WDATA[0] && IRQ |-> ##2 !IRQ)
		else $error("interrupt stays after clear");
	a_soft_reset_quiet: assert property (WR && ADDR == `TWS_OFS_CTRL && WDATA[7] |-> ##3 !IRQ [*2])
		else $error("interrupt during controller reset");
endmodule : tws_props
bind tws_ctrl tws_props tws_props_inst (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .SDA_OE(SDA_OE), .SCL_OE(SCL_OE), .IRQ(IRQ));

/* testbench/tws_slave.sv */
// serial bus device model: acks writes, sends a fixed byte on reads
`timescale 1ns/1ps
module tws_slave #(
	parameter logic [7:0] RD_BYTE = 8'ha5
) (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic rd,
	output logic      sda_oe
);
	int n;
	initial begin
		n = 0;
		sda_oe = 1'b0;
	end
	// start or repeated start restarts the count
	always @(negedge sda) begin
		if (scl) n = 0;
	end
	// changes only while clock low, msb first, ack on ninth clock
	always @(negedge scl) begin
		if (n == 8) sda_oe <= !rd;
		else sda_oe <= rd && !RD_BYTE[7 - n];
		n = (n == 8) ? 0 : n + 1;
	end
endmodule : tws_slave

/* testbench/tb_tws_ctrl.sv */
// self-checking bench for the two-wire controller
`timescale 1ns/1ps
`include "tws_regs.svh"
module tb_tws_ctrl;
	logic        CLK, NRST, WR, RD, SDA_O, SDA_OE, SCL_O, SCL_OE, IRQ, s_oe, s_rd;
	logic [31:0] ADDR, WDATA, RDATA, rv, pv;
	logic [8:0]  bits;
	int          failures, checks, n;
	wire logic   SDA_I = !(SDA_OE || s_oe);
	wire logic   SCL_I = !SCL_OE;
	tws_ctrl tws_ctrl_inst (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .IRQ(IRQ));
	tws_slave tws_slave_inst (.scl(SCL_I), .sda(SDA_I), .rd(s_rd), .sda_oe(s_oe));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge SCL_I) bits <= {bits[7:0], SDA_I};
	// ======
	// tasks
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : cmp
	task automatic results();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic give_up();
		failures++;
		results();
	endtask : give_up
	// one write or read; read data land in rv
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		ADDR  <= a;
		WDATA <= d;
		WR    <= w;
		RD    <= !w;
		@(posedge CLK);
		WR <= 1'b0;
		RD <= 1'b0;
		#1;
		rv = RDATA;
		@(posedge CLK);
	endtask : bus
	task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] v);
		rv = ~v;
		for (n = 0; n < 500 && (rv & m) !== v; n++) bus(0, a, 0);
		if (n == 500) give_up();
	endtask : poll
	// waits for a clock rise; n is the cycles since the last one
	task automatic rise();
		logic p;
		p = 1'b1;
		for (n = 0; n < 5000 && !(SCL_I && !p); n++) begin
			p = SCL_I;
			@(posedge CLK);
			#1;
		end
		if (n == 5000) give_up();
	endtask : rise
	// ======
	// sequence
	initial begin
		NRST = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 32'h0;
		WDATA = 32'h0;
		s_rd = 1'b0;
		bits = 9'h0;
		failures = 0;
		checks = 0;
		repeat (20) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		bus(0, `TWS_OFS_PRESCALE, 0);
		cmp(rv, 0);
		bus(0, `TWS_OFS_COUNT, 0);
		cmp(rv, 0);
		bus(0, `TWS_OFS_PEND, 0);
		cmp(rv, 0);
		bus(0, 32'hf00f0020, 0);
		cmp(rv, 0);
		bus(1, `TWS_OFS_PRESCALE, 32'hffff1234);
		bus(0, `TWS_OFS_PRESCALE, 0);
		cmp(rv, 32'h1234);
		// write byte at prescale zero
		bus(1, `TWS_OFS_PRESCALE, 0);
		bus(1, `TWS_OFS_IMASK, 1);
		bus(1, `TWS_OFS_BUF, 32'hc3);
		bus(1, `TWS_OFS_CTRL, 32'h10);
		bus(0, `TWS_OFS_CTRL, 0);
		cmp(rv & 32'h40, 32'h40);
		rise();
		rise();
		cmp(n, 19);
		poll(`TWS_OFS_PEND, 1, 1);
		cmp(bits, {8'hc3, 1'b0});
		cmp(IRQ, 1);
		bus(0, `TWS_OFS_CTRL, 0);
		cmp(rv & 32'h44, 32'h44);
		bus(0, `TWS_OFS_BUF, 0);
		cmp(rv, 32'hc3);
		bus(1, `TWS_OFS_PEND, 1);
		bus(0, `TWS_OFS_PEND, 0);
		cmp(rv, 0);
		cmp(IRQ, 0);
		bus(1, `TWS_OFS_CTRL, 32'h20);
		poll(`TWS_OFS_CTRL, 32'h40, 0);
		// read byte at prescale one, masked
		s_rd <= 1'b1;
		bus(1, `TWS_OFS_IMASK, 0);
		bus(1, `TWS_OFS_PRESCALE, 1);
		bus(1, `TWS_OFS_CTRL, 32'h19);
		rise();
		rise();
		cmp(n, 35);
		poll(`TWS_OFS_PEND, 1, 1);
		cmp(bits, {8'ha5, 1'b0});
		cmp({SDA_O, SCL_O}, 0);
		cmp(IRQ, 0);
		// counter runs while the byte is held
		bus(1, `TWS_OFS_TEST, 1);
		bus(0, `TWS_OFS_COUNT, 0);
		pv = rv;
		cmp(rv < 35, 1);
		bus(0, `TWS_OFS_COUNT, 0);
		cmp(rv != pv, 1);
		bus(1, `TWS_OFS_IMASK, 1);
		bus(0, `TWS_OFS_BUF, 0);
		cmp(rv, 32'ha5);
		cmp(IRQ, 1);
		// repeated start, then controller reset
		bus(1, `TWS_OFS_CTRL, 32'h39);
		rise();
		bus(1, `TWS_OFS_CTRL, 32'h80);
		bus(0, `TWS_OFS_PEND, 0);
		cmp(rv, 0);
		cmp(IRQ, 0);
		bus(0, `TWS_OFS_CTRL, 0);
		cmp(rv & 32'h40, 0);
		bus(1, `TWS_OFS_CTRL, 0);
		results();
	end
endmodule : tb_tws_ctrl
